// ### logic/icf_intr_ctrl.sv
// interrupt control and flag registers with request generation, apb slave
// Notes on behaviour
// - legacy mode: bit 7 gates every interrupt
// - priority mode: bit 7 enables high priority
// - legacy mode: bit 6 gates peripheral sources
// - priority mode: bit 6 enables low priority
// - timer0, pin0, port change enables mask
// - timer0 overflow and pin0 set sticky flags
// - upper port b change sets flag
// - mismatch keeps setting; port read ends it
// - pull-up disable bit overrides port latches
// - edge bits pick rising or falling
// - priority bits route sources high or low
// - pins 3..1 enables mask their sources
// - pins 3..1 events set sticky flags
// - flags set regardless of any enable
// - parallel port and converter set flags
// - receive flag mirrors buffer full, read-only
// - transmit flag mirrors buffer empty, read-only
// - synchronous serial completion sets flag
// - capture/compare event flags, not waveform
// - timer2 match, timer1 overflow set flags
// - reset control bit 7 selects priority
// - pending enabled interrupt requests its vector
//
// Chosen here: the register offsets and the APB register port.
module icf_intr_ctrl
  import icf_pkg::*;
(
  // apb clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // external pins 0 to 3 and upper port b inputs
  input  wire logic [3:0]        extpin,
  input  wire logic [3:0]        port_b_inputs,
  // same-clock peripheral events, one-cycle pulses
  input  wire logic              timer_zero_overflow,
  input  wire logic              parallel_port_done,
  input  wire logic              conversion_done,
  input  wire logic              sync_serial_done,
  input  wire logic              capcomp_event,
  input  wire logic [1:0]        capcomp_mode,
  input  wire logic              timer_two_match,
  input  wire logic              timer_one_overflow,
  // async serial unit buffer levels
  input  wire logic              serial_rx_full,
  input  wire logic              serial_tx_empty,
  // peripheral enables and priorities from the outside registers
  input  wire logic [7:0]        periph_enable,
  input  wire logic [7:0]        periph_priority,
  // to the processor core and port pads
  output logic                   irq_high,
  output logic                   irq_low,
  output logic [15:0]            irq_vector,
  output logic                   port_pullup_disable,
  output logic [3:0]             port_pullup_enable
);
  // register state
  logic [7:0]  ctrl_main_q;
  logic [7:0]  ctrl_main_d;
  logic [7:0]  ctrl_edge_q;
  logic [7:0]  ctrl_edge_d;
  logic [7:0]  ctrl_ext_q;
  logic [7:0]  ctrl_ext_d;
  logic [7:0]  preq_q;
  logic [7:0]  preq_d;
  logic [7:0]  rst_ctrl_q;
  logic [7:0]  rst_ctrl_d;
  logic [3:0]  port_latch_q;
  logic [3:0]  port_latch_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        irq_high_q;
  logic        irq_low_q;
  logic [15:0] vector_q;
  logic [15:0] vector_d;

  // pin synchronisers
  logic [3:0]  ext_level;
  logic [3:0]  ext_evt;
  logic [3:0]  pb_level;
  logic [3:0]  edge_sel;

  // edge select bits sit at 6 down to 3 for pins 0 to 3
  assign edge_sel = {ctrl_edge_q[B_EDGE0-3], ctrl_edge_q[B_EDGE0-2],
                     ctrl_edge_q[B_EDGE0-1], ctrl_edge_q[B_EDGE0]};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_pins
      icf_pin_sync u_ext (
        .pclk       (pclk),
        .presetn    (presetn),
        .pin        (extpin[gi]),
        .rise_sel   (edge_sel[gi]),
        .level      (ext_level[gi]),
        .edge_pulse (ext_evt[gi])
      );
      // port b pins only need the level
      icf_pin_sync u_pb (
        .pclk       (pclk),
        .presetn    (presetn),
        .pin        (port_b_inputs[gi]),
        .rise_sel   (1'b1),
        .level      (pb_level[gi]),
        .edge_pulse ()
      );
    end
  endgenerate

  // apb decode, zero wait states
  logic       setup_ph;
  logic       acc_wr;
  logic       acc_rd;
  logic       hit_main;
  logic       hit_edge;
  logic       hit_ext;
  logic       hit_preq;
  logic       hit_rst;
  logic       hit_port;
  logic       hit_stat;
  logic       mapped;
  logic       wr_ok;
  logic [7:0] wbyte;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    hit = (a == off[ADDR_W-1:0]);
  endfunction

  assign setup_ph = psel & ~penable;
  assign hit_main = hit(paddr, OFF_CTRL_MAIN);
  assign hit_edge = hit(paddr, OFF_CTRL_EDGE_PRIO);
  assign hit_ext  = hit(paddr, OFF_CTRL_EXTPIN);
  assign hit_preq = hit(paddr, OFF_PERIPH_REQ_ONE);
  assign hit_rst  = hit(paddr, OFF_RESET_CTRL);
  assign hit_port = hit(paddr, OFF_PORT_B);
  assign hit_stat = hit(paddr, OFF_REQ_STATUS);
  assign mapped   = hit_main | hit_edge | hit_ext | hit_preq | hit_rst | hit_port | hit_stat;
  // only byte lane 0 carries data; writes without it change nothing
  assign wr_ok    = psel & penable & pwrite & mapped & pstrb[0];
  assign acc_rd   = psel & penable & ~pwrite & mapped;
  assign acc_wr   = wr_ok;
  assign wbyte    = pwdata[7:0];
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~mapped;
  assign prdata   = prdata_q;

  // port change detection against the value last read or written to the port
  logic pchg_mismatch;
  logic port_read;
  assign port_read     = acc_rd & hit_port;
  assign pchg_mismatch = (pb_level != port_latch_q);

  assign port_pullup_disable = ctrl_edge_q[B_PULLUP_DIS];
  assign port_pullup_enable  = port_pullup_disable ? 4'h0 : port_latch_q;

  // hardware set vectors, same bit layout as the registers
  logic [7:0] main_set;
  logic [7:0] ext_set;
  logic [7:0] preq_set;
  logic       ccp_active;

  // flag only in capture or compare mode
  assign ccp_active = (capcomp_mode == ICF_CCP_CAPTURE) | (capcomp_mode == ICF_CCP_COMPARE);

  // port change from any upper pin
  assign main_set = {5'h00, timer_zero_overflow, ext_evt[0], pchg_mismatch};
  assign ext_set  = {5'h00, ext_evt[3], ext_evt[2], ext_evt[1]};
  assign preq_set = {parallel_port_done, conversion_done, 2'b00, sync_serial_done,
                     capcomp_event & ccp_active, timer_two_match, timer_one_overflow};

  // next state of the software registers
  // write first, then hardware sets on top so no event is lost
  always_comb
  begin
    ctrl_main_d  = ctrl_main_q;
    ctrl_edge_d  = ctrl_edge_q;
    ctrl_ext_d   = ctrl_ext_q;
    preq_d       = preq_q;
    rst_ctrl_d   = rst_ctrl_q;
    port_latch_d = port_latch_q;
    if (acc_wr && hit_main)
      ctrl_main_d = wbyte;
    if (acc_wr && hit_edge)
      ctrl_edge_d = wbyte;
    if (acc_wr && hit_ext)
      ctrl_ext_d = wbyte;
    if (acc_wr && hit_preq)
      preq_d = wbyte & PREQ_SW_MASK;
    if (acc_wr && hit_rst)
      rst_ctrl_d = wbyte & (8'h01 << B_PRIO_MODE);
    if (acc_wr && hit_port)
      port_latch_d = wbyte[3:0];
    if (port_read)
      port_latch_d = pb_level;
    ctrl_main_d = ctrl_main_d | main_set;
    ctrl_ext_d  = ctrl_ext_d | ext_set;
    // receive flag follows the buffer level
    // transmit flag follows the buffer level
    preq_d = (preq_d | preq_set) & PREQ_SW_MASK;
    preq_d[B_RX_FLAG] = serial_rx_full;
    preq_d[B_TX_FLAG] = serial_tx_empty;
  end

  // read mux, captured in the setup phase for the access phase
  always_comb
  begin
    prdata_d = 32'h0000_0000;
    if (hit_main)
      prdata_d[7:0] = ctrl_main_q;
    if (hit_edge)
      prdata_d[7:0] = ctrl_edge_q;
    if (hit_ext)
      prdata_d[7:0] = ctrl_ext_q;
    if (hit_preq)
      prdata_d[7:0] = preq_q;
    if (hit_rst)
      prdata_d[7:0] = rst_ctrl_q;
    if (hit_port)
      prdata_d[7:0] = {4'h0, pb_level};
    if (hit_stat)
      prdata_d[7:0] = {6'h00, irq_low_q, irq_high_q};
  end

  // request generation
  logic [5:0] core_pend;
  logic [5:0] core_prio;
  logic [7:0] periph_pend;
  logic       prio_mode;
  logic       gie_h;
  logic       gie_l;
  logic       legacy_req;
  logic       high_req;
  logic       low_req;

  // priority mode from reset control bit 7
  assign prio_mode = rst_ctrl_q[B_PRIO_MODE];
  assign gie_h     = ctrl_main_q[B_GLOBAL_HIGH_EN];
  assign gie_l     = ctrl_main_q[B_PERIPH_LOW_EN];

  // enables for timer0, pin0, port change and pins 3..1
  assign core_pend = {ctrl_main_q[B_TMR0_FLAG] & ctrl_main_q[B_TMR0_EN],
                      ctrl_main_q[B_EXT0_FLAG] & ctrl_main_q[B_EXT0_EN],
                      ctrl_main_q[B_PCHG_FLAG] & ctrl_main_q[B_PCHG_EN],
                      ctrl_ext_q[B_EXT1_FLAG+2] & ctrl_ext_q[B_EXT1_EN+2],
                      ctrl_ext_q[B_EXT1_FLAG+1] & ctrl_ext_q[B_EXT1_EN+1],
                      ctrl_ext_q[B_EXT1_FLAG] & ctrl_ext_q[B_EXT1_EN]};
  // priority routing, pin0 is always high
  assign core_prio = {ctrl_edge_q[B_TMR0_PRIO], 1'b1, ctrl_edge_q[B_PCHG_PRIO],
                      ctrl_edge_q[B_EXT3_PRIO], ctrl_ext_q[B_EXT2_PRIO], ctrl_ext_q[B_EXT1_PRIO]};
  assign periph_pend = preq_q & periph_enable;

  assign legacy_req = gie_h & ((|core_pend) | (gie_l & (|periph_pend)));
  assign high_req   = gie_h & ((|(core_pend & core_prio)) | (|(periph_pend & periph_priority)));
  assign low_req    = gie_h & gie_l & ((|(core_pend & ~core_prio)) | (|(periph_pend & ~periph_priority)));

  // vector selection, high wins, legacy always 0008h
  always_comb
  begin
    vector_d = vector_q;
    if (!prio_mode && legacy_req)
      vector_d = VEC_HIGH;
    else if (prio_mode && high_req)
      vector_d = VEC_HIGH;
    else if (prio_mode && low_req)
      vector_d = VEC_LOW;
  end

  // register update
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_main_q  <= RST_CTRL_MAIN;
      ctrl_edge_q  <= RST_CTRL_EDGE_PRIO;
      ctrl_ext_q   <= RST_CTRL_EXTPIN;
      preq_q       <= RST_PERIPH_REQ_ONE;
      rst_ctrl_q   <= RST_RESET_CTRL;
      port_latch_q <= RST_PORT_LATCH;
    end
    else
    begin
      ctrl_main_q  <= ctrl_main_d;
      ctrl_edge_q  <= ctrl_edge_d;
      ctrl_ext_q   <= ctrl_ext_d;
      preq_q       <= preq_d;
      rst_ctrl_q   <= rst_ctrl_d;
      port_latch_q <= port_latch_d;
    end
  end

  // bus read data and core request outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q   <= 32'h0000_0000;
      irq_high_q <= 1'b0;
      irq_low_q  <= 1'b0;
      vector_q   <= VEC_HIGH;
    end
    else
    begin
      if (setup_ph)
        prdata_q <= prdata_d;
      irq_high_q <= prio_mode ? high_req : legacy_req;
      irq_low_q  <= prio_mode & ~high_req & low_req;
      vector_q   <= vector_d;
    end
  end

  assign irq_high   = irq_high_q;
  assign irq_low    = irq_low_q;
  assign irq_vector = vector_q;

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  legacy_gate_a: assert property (!prio_mode && !gie_h |=> !irq_high && !irq_low)
    else $error("request raised with global enable clear");
  high_vec_a: assert property (prio_mode && high_req |=> irq_high && irq_vector == 16'h0008)
    else $error("high request without vector 0008");
  low_vec_a: assert property (prio_mode && !high_req && low_req |=> irq_low && irq_vector == 16'h0018)
    else $error("low request without vector 0018");
  periph_gate_a: assert property (!prio_mode && !gie_l && core_pend == 6'h00 |=> !irq_high)
    else $error("peripheral passed with peripheral gate clear");
  tmr0_set_a: assert property (timer_zero_overflow |=> ctrl_main_q[B_TMR0_FLAG])
    else $error("timer0 flag not set");
  set_wins_a: assert property (acc_wr && hit_preq && wbyte == 8'h00 && timer_one_overflow
                              |=> preq_q[B_TMR1_FLAG])
    else $error("clear beat a hardware set");
  mismatch_hold_a: assert property (pchg_mismatch |=> ctrl_main_q[B_PCHG_FLAG])
    else $error("port change flag lost during mismatch");
  rx_mirror_a: assert property (serial_rx_full |=> preq_q[B_RX_FLAG])
    else $error("receive flag not following buffer");
  tx_mirror_a: assert property (!serial_tx_empty |=> !preq_q[B_TX_FLAG])
    else $error("transmit flag not following buffer");
  ccp_wave_a: assert property (capcomp_mode == ICF_CCP_WAVE && !(acc_wr && hit_preq) && !preq_q[B_CCP_FLAG]
                              |=> !preq_q[B_CCP_FLAG])
    else $error("capture flag set in waveform mode");
  pullup_a: assert property (port_pullup_disable |-> port_pullup_enable == 4'h0)
    else $error("pull-up on while disabled");

  legacy_irq_c: cover property (!prio_mode && irq_high);
  low_irq_c: cover property (prio_mode ##1 irq_low);
  pchg_c: cover property (pchg_mismatch ##1 port_read);
endmodule

// ### logic/icf_pin_sync.sv
// two-stage synchroniser with selectable edge detection for one pin
module icf_pin_sync
  import icf_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // pin side
  input  wire logic pin,
  input  wire logic rise_sel,
  // synchronised results
  output logic      level,
  output logic      edge_pulse
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  // first stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      meta_q <= pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // edge chosen by the select bit, one cycle wide
  assign level      = sync_q;
  assign edge_pulse = rise_sel ? (sync_q & ~prev_q) : (~sync_q & prev_q);
endmodule

// ### logic/icf_pkg.sv
// constants shared by the interrupt control and flag block
package icf_pkg;
  // apb address width and register byte offsets
  localparam int unsigned ADDR_W              = 8;
  localparam logic [7:0] OFF_CTRL_MAIN        = 8'h00;
  localparam logic [7:0] OFF_CTRL_EDGE_PRIO   = 8'h04;
  localparam logic [7:0] OFF_CTRL_EXTPIN      = 8'h08;
  localparam logic [7:0] OFF_PERIPH_REQ_ONE   = 8'h0c;
  localparam logic [7:0] OFF_RESET_CTRL       = 8'h10;
  localparam logic [7:0] OFF_PORT_B           = 8'h14;
  localparam logic [7:0] OFF_REQ_STATUS       = 8'h18;

  // values after reset
  localparam logic [7:0] RST_CTRL_MAIN        = 8'h00;
  localparam logic [7:0] RST_CTRL_EDGE_PRIO   = 8'hff;
  localparam logic [7:0] RST_CTRL_EXTPIN      = 8'hc0;
  localparam logic [7:0] RST_PERIPH_REQ_ONE   = 8'h00;
  localparam logic [7:0] RST_RESET_CTRL       = 8'h00;
  localparam logic [3:0] RST_PORT_LATCH       = 4'h0;

  // main control register fields
  localparam int unsigned B_GLOBAL_HIGH_EN    = 7;
  localparam int unsigned B_PERIPH_LOW_EN     = 6;
  localparam int unsigned B_TMR0_EN           = 5;
  localparam int unsigned B_EXT0_EN           = 4;
  localparam int unsigned B_PCHG_EN           = 3;
  localparam int unsigned B_TMR0_FLAG         = 2;
  localparam int unsigned B_EXT0_FLAG         = 1;
  localparam int unsigned B_PCHG_FLAG         = 0;

  // edge and priority register fields
  localparam int unsigned B_PULLUP_DIS        = 7;
  localparam int unsigned B_EDGE0             = 6;
  localparam int unsigned B_TMR0_PRIO         = 2;
  localparam int unsigned B_EXT3_PRIO         = 1;
  localparam int unsigned B_PCHG_PRIO         = 0;

  // external pin register fields, pins 1 to 3
  localparam int unsigned B_EXT2_PRIO         = 7;
  localparam int unsigned B_EXT1_PRIO         = 6;
  localparam int unsigned B_EXT1_EN           = 3;
  localparam int unsigned B_EXT1_FLAG         = 0;

  // peripheral request register fields
  localparam int unsigned B_PMP_FLAG          = 7;
  localparam int unsigned B_ADC_FLAG          = 6;
  localparam int unsigned B_RX_FLAG           = 5;
  localparam int unsigned B_TX_FLAG           = 4;
  localparam int unsigned B_SSP_FLAG          = 3;
  localparam int unsigned B_CCP_FLAG          = 2;
  localparam int unsigned B_TMR2_FLAG         = 1;
  localparam int unsigned B_TMR1_FLAG         = 0;
  localparam logic [7:0] PREQ_SW_MASK         = 8'hcf;

  // reset control register field
  localparam int unsigned B_PRIO_MODE         = 7;

  // vector addresses
  localparam logic [15:0] VEC_HIGH            = 16'h0008;
  localparam logic [15:0] VEC_LOW             = 16'h0018;

  // capture/compare unit modes
  typedef enum logic [1:0] {
    ICF_CCP_OFF     = 2'h0,
    ICF_CCP_CAPTURE = 2'h1,
    ICF_CCP_COMPARE = 2'h2,
    ICF_CCP_WAVE    = 2'h3
  } icf_ccp_mode_e;
endpackage

// ### verif/icf_periph_model.sv
// peripheral event sources and serial buffer levels facing the flag block
module icf_periph_model
  import icf_pkg::*;
(
  // clock
  input  wire logic pclk,
  // one-cycle completion events
  output logic       timer_zero_overflow,
  output logic       parallel_port_done,
  output logic       conversion_done,
  output logic       sync_serial_done,
  output logic       capcomp_event,
  output logic       timer_two_match,
  output logic       timer_one_overflow,
  // capture/compare mode and serial buffer levels
  output logic [1:0] capcomp_mode,
  output logic       serial_rx_full,
  output logic       serial_tx_empty
);
  timeunit 1ns;
  timeprecision 100ps;

  // slot n is the request bit n; slot 5 carries the timer 0 overflow
  logic [7:0] ev_q = 8'h00;

  // events are single-cycle pulses, never stretched
  assign parallel_port_done  = ev_q[7];
  assign conversion_done     = ev_q[6];
  assign timer_zero_overflow = ev_q[5];
  assign sync_serial_done    = ev_q[3];
  assign capcomp_event       = ev_q[2];
  assign timer_two_match     = ev_q[1];
  assign timer_one_overflow  = ev_q[0];

  initial
  begin
    capcomp_mode    = ICF_CCP_CAPTURE;
    serial_rx_full  = 1'b0;
    serial_tx_empty = 1'b0;
  end

  // one event for one clock, launched right after an edge
  task automatic pulse(input int b);
    @(posedge pclk);
    ev_q[b] <= 1'b1;
    @(posedge pclk);
    ev_q[b] <= 1'b0;
  endtask

  // buffer levels and unit mode change only right after an edge
  task automatic levels(input logic rx, input logic tx, input logic [1:0] m);
    @(posedge pclk);
    serial_rx_full  <= rx;
    serial_tx_empty <= tx;
    capcomp_mode    <= m;
  endtask
endmodule

// ### verif/tb_icf_intr_ctrl.sv
// self-checking bench for the interrupt control and flag block
module tb_icf_intr_ctrl
  import icf_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // clock, reset and apb master
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hf;
  // pins and outside enables
  logic [3:0]  extpin = 4'h0;
  logic [3:0]  port_b_inputs = 4'h0;
  logic [7:0]  periph_enable = 8'hff;
  logic [7:0]  periph_priority = 8'h00;
  // design outputs and model nets
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        irq_high;
  logic        irq_low;
  logic [15:0] irq_vector;
  logic        port_pullup_disable;
  logic [3:0]  port_pullup_enable;
  logic        timer_zero_overflow;
  logic        parallel_port_done;
  logic        conversion_done;
  logic        sync_serial_done;
  logic        capcomp_event;
  logic [1:0]  capcomp_mode;
  logic        timer_two_match;
  logic        timer_one_overflow;
  logic        serial_rx_full;
  logic        serial_tx_empty;
  int          fail_count = 0;
  int          check_count = 0;
  int          evs[6] = '{7, 6, 3, 2, 1, 0};

  always #10 pclk = ~pclk;

  icf_intr_ctrl u_icf_intr_ctrl (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr,
    .extpin, .port_b_inputs, .timer_zero_overflow, .parallel_port_done, .conversion_done,
    .sync_serial_done, .capcomp_event, .capcomp_mode, .timer_two_match, .timer_one_overflow,
    .serial_rx_full, .serial_tx_empty, .periph_enable, .periph_priority, .irq_high, .irq_low,
    .irq_vector, .port_pullup_disable, .port_pullup_enable
  );

  icf_periph_model u_icf_periph_model (
    .pclk, .timer_zero_overflow, .parallel_port_done, .conversion_done, .sync_serial_done,
    .capcomp_event, .timer_two_match, .timer_one_overflow, .capcomp_mode, .serial_rx_full,
    .serial_tx_empty
  );

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // one transfer: setup, access held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: only the watchdog ends a stuck wait
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, {24'h0, d}, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic ee = 1'b0);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk($sformatf("reg %h", a), r, exp);
    chk("pslverr", {31'h0, e}, {31'h0, ee});
  endtask

  // request outputs settle two edges after their cause
  task automatic irq(input logic h, input logic l, input logic [15:0] v);
    wt(3);
    chk("irq_high", {31'h0, irq_high}, {31'h0, h});
    chk("irq_low", {31'h0, irq_low}, {31'h0, l});
    chk("irq_vector", {16'h0, irq_vector}, {16'h0, v});
  endtask

  // watchdog, far beyond the few hundred cycles the sequence needs
  initial
  begin
    #200us;
    fail_count++;
    conclude();
  end

  initial
  begin
    wt(3);
    presetn <= 1'b1;
    chk("pullup_disable", {31'h0, port_pullup_disable}, 32'h1);
    rd(OFF_CTRL_MAIN, 32'h00);
    rd(OFF_CTRL_EDGE_PRIO, 32'hff);
    rd(OFF_CTRL_EXTPIN, 32'hc0);
    rd(OFF_PERIPH_REQ_ONE, 32'h00);
    rd(8'h40, 32'h0, 1'b1);
    // timer 0 flag with every enable off, then enabled and masked
    u_icf_periph_model.pulse(5);
    rd(OFF_CTRL_MAIN, 32'h04);
    irq(1'b0, 1'b0, VEC_HIGH);
    wr(OFF_CTRL_MAIN, 8'ha4);
    irq(1'b1, 1'b0, VEC_HIGH);
    wr(OFF_CTRL_MAIN, 8'h84);
    irq(1'b0, 1'b0, VEC_HIGH);
    wr(OFF_CTRL_MAIN, 8'h00);
    rd(OFF_CTRL_MAIN, 32'h00);
    // every pulsed peripheral source, then global gating in both modes
    foreach (evs[i])
      u_icf_periph_model.pulse(evs[i]);
    rd(OFF_PERIPH_REQ_ONE, 32'hcf);
    wr(OFF_CTRL_MAIN, 8'h80);
    irq(1'b0, 1'b0, VEC_HIGH);
    wr(OFF_CTRL_MAIN, 8'hc0);
    irq(1'b1, 1'b0, VEC_HIGH);
    wr(OFF_RESET_CTRL, 8'h80);
    irq(1'b0, 1'b1, VEC_LOW);
    rd(OFF_RESET_CTRL, 32'h80);
    rd(OFF_REQ_STATUS, 32'h02);
    wr(OFF_CTRL_MAIN, 8'h80);
    irq(1'b0, 1'b0, VEC_LOW);
    wr(OFF_CTRL_MAIN, 8'h40);
    irq(1'b0, 1'b0, VEC_LOW);
    @(posedge pclk) periph_priority <= 8'hff;
    wr(OFF_CTRL_MAIN, 8'h80);
    irq(1'b1, 1'b0, VEC_HIGH);
    wr(OFF_CTRL_MAIN, 8'h00);
    wr(OFF_RESET_CTRL, 8'h00);
    wr(OFF_PERIPH_REQ_ONE, 8'h00);
    rd(OFF_PERIPH_REQ_ONE, 32'h00);
    // serial mirrors ignore writes
    u_icf_periph_model.levels(1'b1, 1'b0, ICF_CCP_WAVE);
    wr(OFF_PERIPH_REQ_ONE, 8'hff);
    rd(OFF_PERIPH_REQ_ONE, 32'hef);
    u_icf_periph_model.levels(1'b0, 1'b1, ICF_CCP_WAVE);
    wr(OFF_PERIPH_REQ_ONE, 8'h00);
    rd(OFF_PERIPH_REQ_ONE, 32'h10);
    u_icf_periph_model.levels(1'b0, 1'b0, ICF_CCP_WAVE);
    u_icf_periph_model.pulse(2);
    rd(OFF_PERIPH_REQ_ONE, 32'h00);
    u_icf_periph_model.levels(1'b0, 1'b0, ICF_CCP_COMPARE);
    u_icf_periph_model.pulse(2);
    rd(OFF_PERIPH_REQ_ONE, 32'h04);
    fork
      wr(OFF_PERIPH_REQ_ONE, 8'h00);
      begin
        wt(1);
        u_icf_periph_model.pulse(0);
      end
    join
    rd(OFF_PERIPH_REQ_ONE, 32'h01);
    // rising edges on pins 0 and 1, then pin 2 on falling only
    @(posedge pclk) extpin <= 4'h3;
    wt(6);
    rd(OFF_CTRL_EXTPIN, 32'hc1);
    rd(OFF_CTRL_MAIN, 32'h02);
    wr(OFF_CTRL_EDGE_PRIO, 8'hef);
    @(posedge pclk) extpin <= 4'h7;
    wt(6);
    rd(OFF_CTRL_EXTPIN, 32'hc1);
    @(posedge pclk) extpin <= 4'h3;
    wt(6);
    rd(OFF_CTRL_EXTPIN, 32'hc3);
    wr(OFF_CTRL_MAIN, 8'h80);
    wr(OFF_CTRL_EXTPIN, 8'hd2);
    irq(1'b1, 1'b0, VEC_HIGH);
    wr(OFF_CTRL_EXTPIN, 8'hc2);
    irq(1'b0, 1'b0, VEC_HIGH);
    wr(OFF_CTRL_MAIN, 8'h00);
    // port change flag cannot be cleared until the port is read
    @(posedge pclk) port_b_inputs <= 4'h9;
    wt(6);
    rd(OFF_CTRL_MAIN, 32'h01);
    wr(OFF_CTRL_MAIN, 8'h00);
    rd(OFF_CTRL_MAIN, 32'h01);
    rd(OFF_PORT_B, 32'h09);
    wr(OFF_CTRL_MAIN, 8'h00);
    rd(OFF_CTRL_MAIN, 32'h00);
    // pull-ups follow the latch only while not disabled
    wr(OFF_CTRL_EDGE_PRIO, 8'h7f);
    wr(OFF_PORT_B, 8'h05);
    wt(2);
    chk("pullup_enable", {28'h0, port_pullup_enable}, 32'h5);
    chk("pullup_disable", {31'h0, port_pullup_disable}, 32'h0);
    wr(OFF_CTRL_EDGE_PRIO, 8'hff);
    wt(2);
    chk("pullup_enable", {28'h0, port_pullup_enable}, 32'h0);
    conclude();
  end
endmodule
